// ### design/sfe_pkg.sv
// Constants and types shared by the serial flash erase sequencer
package sfe_pkg;
  localparam int unsigned SYS_CLK_KHZ = 10000;
  // Erase durations in milliseconds, typical figures
  localparam int unsigned SECTOR_ERASE_DURATION_MS = 100;
  localparam int unsigned BLOCK32_ERASE_DURATION_MS = 300;
  localparam int unsigned BLOCK64_ERASE_DURATION_MS = 500;
  localparam int unsigned CHIP_ERASE_DURATION_MS = 800;
  localparam int unsigned SECTOR_ERASE_CYCLES =
    SECTOR_ERASE_DURATION_MS * SYS_CLK_KHZ;
  localparam int unsigned BLOCK32_ERASE_CYCLES =
    BLOCK32_ERASE_DURATION_MS * SYS_CLK_KHZ;
  localparam int unsigned BLOCK64_ERASE_CYCLES =
    BLOCK64_ERASE_DURATION_MS * SYS_CLK_KHZ;
  localparam int unsigned CHIP_ERASE_CYCLES =
    CHIP_ERASE_DURATION_MS * SYS_CLK_KHZ;
  localparam int TIMER_W = 24;
  // Opcodes
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  // Frame lengths in serial clock edges
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] ADDR_CMD_BITS = 6'h20;
  localparam logic [5:0] BIT_CNT_MAX = 6'h21;
  // Memory geometry, 128 KB
  localparam int ADDR_W = 17;
  localparam logic [17:0] MEM_BYTES = 18'h20000;
  localparam logic [17:0] SECTOR_BYTES = 18'h01000;
  localparam logic [17:0] BLOCK32_BYTES = 18'h08000;
  localparam logic [17:0] BLOCK64_BYTES = 18'h10000;
  localparam logic [2:0] PROT_ALL_LEVEL = 3'h5;
  // Status byte fields
  localparam int STAT_WIP_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  localparam int STAT_PROT_LSB = 2;

  typedef enum logic [1:0] {
    SFE_KIND_SECTOR,
    SFE_KIND_BLOCK32,
    SFE_KIND_BLOCK64,
    SFE_KIND_CHIP
  } sfe_kind_t;

  typedef struct packed {
    sfe_kind_t kind;
    logic [ADDR_W-1:0] base;
  } sfe_erase_t;
endpackage

// ### design/sfe_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module sfe_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_reg <= INIT;
      sync_out <= INIT;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// ### design/sfe_timer.sv
// Down-counter that times the self-timed erase cycle
`timescale 1ns/100ps
module sfe_timer #(
  parameter int WIDTH = 24
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  output logic done
);
  logic [WIDTH-1:0] cnt_reg;
  logic run_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_reg <= load_val;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cnt_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          run_reg <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// ### design/sfe_erase_ctrl.sv
// Serial flash erase command decoder and self-timed erase sequencer
//
// Behaviour
// - Sector erase: select low, opcode 20h, then three address bytes.
// - Sector or block erase runs only with write_enable_latch set.
// - Any address inside a 4KB sector erases that whole sector.
// - Select stays low for the whole erase command.
// - Select rising other than after the last address bit discards it.
// - Erase cycle starts on the select rise ending a valid command.
// - write_in_progress is 1 during the erase cycle, 0 after.
// - Status reads still served while sector or block erase runs.
// - write_enable_latch cleared before sector or block erase finishes.
// - Sector erase refused when the sector is protected.
// - Opcode 52h plus address erases the enclosing 32KB block.
// - Opcode d8h plus address erases the enclosing 64KB block.
// - Block erase refused when the block is protected.
// - Chip erase is opcode c7h or 60h alone; all bytes become ffh.
// - Chip erase accepted only with write_enable_latch equal 1.
// - Chip erase starts only if select rises right after eighth bit.
// - Chip erase: busy reads 1, status served, accepts commands after.
// - write_enable_latch cleared to 0 after chip erase finishes.
// - Chip erase refused when any protect_level is nonzero.
// - Block erase lasts about 0.3 s (32KB) or 0.5 s (64KB).
`timescale 1ns/100ps
module sfe_erase_ctrl
  import sfe_pkg::*;
#(
  parameter int unsigned SECTOR_CYCLES = SECTOR_ERASE_CYCLES,
  parameter int unsigned BLOCK32_CYCLES = BLOCK32_ERASE_CYCLES,
  parameter int unsigned BLOCK64_CYCLES = BLOCK64_ERASE_CYCLES,
  parameter int unsigned CHIP_CYCLES = CHIP_ERASE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sel_n_pin,
  input wire logic sclk_pin,
  input wire logic si_pin,
  input wire logic [2:0] protect_level,
  output logic so_out,
  output logic so_oe,
  output logic write_in_progress,
  output logic write_enable_latch,
  output logic erase_start,
  output sfe_erase_t erase_req
);
  typedef enum logic {SFE_IDLE, SFE_ERASING} sfe_state_t;

  logic [2:0] pins_sync;
  logic sel_n_s;
  logic sclk_s;
  logic si_s;
  logic sel_n_d_reg;
  logic sclk_d_reg;
  logic sel_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic [5:0] bit_cnt_reg;
  logic [31:0] shift_reg;
  logic [31:0] shift_next;
  logic rd_status_reg;
  logic [2:0] out_idx_reg;
  logic [7:0] status_byte;
  logic [7:0] status_hold_reg;
  sfe_state_t state_reg;
  logic wip_reg;
  logic wel_reg;
  logic so_reg;
  logic so_oe_reg;
  logic start_reg;
  sfe_erase_t req_reg;
  sfe_kind_t kind_reg;
  logic timer_done;
  logic timer_load;
  logic [TIMER_W-1:0] timer_val;
  // Decode results
  logic [7:0] op8;
  logic [7:0] op32;
  logic [ADDR_W-1:0] cmd_addr;
  logic start_erase;
  sfe_kind_t start_kind;
  logic [17:0] start_size;
  logic [17:0] start_base;
  logic [17:0] prot_floor;
  logic prot_hit;

  sfe_sync #(.WIDTH(3), .INIT(3'h1)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({si_pin, sclk_pin, sel_n_pin}),
    .sync_out(pins_sync)
  );

  assign sel_n_s = pins_sync[0];
  assign sclk_s = pins_sync[1];
  assign si_s = pins_sync[2];

  // The serial clock is oversampled, so edges are found by comparison
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sel_n_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
    end else begin
      sel_n_d_reg <= sel_n_s;
      sclk_d_reg <= sclk_s;
    end
  end

  assign sel_rise = sel_n_s & ~sel_n_d_reg;
  assign sclk_rise = sclk_s & ~sclk_d_reg & ~sel_n_s;
  assign sclk_fall = ~sclk_s & sclk_d_reg & ~sel_n_s;
  assign shift_next = {shift_reg[30:0], si_s};

  // Bit counter saturates so that an over-long frame never aliases
  // back onto a valid length
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bit_cnt_reg <= '0;
      shift_reg <= '0;
    end else if (sel_n_s) begin
      bit_cnt_reg <= '0;
    end else if (sclk_rise) begin
      shift_reg <= shift_next;
      if (bit_cnt_reg != BIT_CNT_MAX) begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
    end
  end

  assign op8 = shift_reg[7:0];
  assign op32 = shift_reg[31:24];
  assign cmd_addr = shift_reg[ADDR_W-1:0];

  always_comb begin
    start_kind = SFE_KIND_SECTOR;
    start_size = SECTOR_BYTES;
    case (op32)
      OP_BLOCK32_ERASE: begin
        start_kind = SFE_KIND_BLOCK32;
        start_size = BLOCK32_BYTES;
      end
      OP_BLOCK64_ERASE: begin
        start_kind = SFE_KIND_BLOCK64;
        start_size = BLOCK64_BYTES;
      end
      default: begin
        start_kind = SFE_KIND_SECTOR;
        start_size = SECTOR_BYTES;
      end
    endcase
    if (bit_cnt_reg == OPCODE_BITS) begin
      start_kind = SFE_KIND_CHIP;
      start_size = MEM_BYTES;
    end
  end

  // Low address bits are dropped so any address selects its unit
  assign start_base = {1'b0, cmd_addr} & ~(start_size - 18'h00001);

  // Protected region grows down from the top of memory
  always_comb begin
    if (protect_level == 3'h0) begin
      prot_floor = MEM_BYTES;
    end else if (protect_level >= PROT_ALL_LEVEL) begin
      prot_floor = '0;
    end else begin
      prot_floor = MEM_BYTES - (SECTOR_BYTES << protect_level);
    end
  end

  assign prot_hit = (start_base + start_size) > prot_floor;

  always_comb begin
    start_erase = 1'b0;
    // Busy, latch clear or malformed frames fall through to no action
    if (sel_rise && !wip_reg && wel_reg) begin
      if (bit_cnt_reg == ADDR_CMD_BITS) begin
        if ((op32 == OP_SECTOR_ERASE || op32 == OP_BLOCK32_ERASE ||
             op32 == OP_BLOCK64_ERASE) && !prot_hit) begin
          start_erase = 1'b1;
        end
      end else if (bit_cnt_reg == OPCODE_BITS) begin
        if ((op8 == OP_CHIP_ERASE_A || op8 == OP_CHIP_ERASE_B) &&
            protect_level == 3'h0) begin
          start_erase = 1'b1;
        end
      end
    end
  end

  always_comb begin
    case (start_kind)
      SFE_KIND_BLOCK32: timer_val = TIMER_W'(BLOCK32_CYCLES);
      SFE_KIND_BLOCK64: timer_val = TIMER_W'(BLOCK64_CYCLES);
      SFE_KIND_CHIP: timer_val = TIMER_W'(CHIP_CYCLES);
      default: timer_val = TIMER_W'(SECTOR_CYCLES);
    endcase
  end

  assign timer_load = start_erase;

  sfe_timer #(.WIDTH(TIMER_W)) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(timer_load),
    .load_val(timer_val),
    .done(timer_done)
  );

  // Sequencer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= SFE_IDLE;
      wip_reg <= 1'b0;
      kind_reg <= SFE_KIND_SECTOR;
    end else begin
      case (state_reg)
        SFE_IDLE: begin
          if (start_erase) begin
            state_reg <= SFE_ERASING;
            wip_reg <= 1'b1;
            kind_reg <= start_kind;
          end
        end
        SFE_ERASING: begin
          if (timer_done) begin
            state_reg <= SFE_IDLE;
            wip_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= SFE_IDLE;
          wip_reg <= 1'b0;
        end
      endcase
    end
  end

  // Erase request handed to the array: base address and extent;
  // a chip request means every byte goes to ffh
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      start_reg <= 1'b0;
      req_reg <= '0;
    end else begin
      start_reg <= start_erase;
      if (start_erase) begin
        req_reg.kind <= start_kind;
        req_reg.base <= start_base[ADDR_W-1:0];
      end
    end
  end

  // Write enable latch; chip erase holds it until the cycle ends
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wel_reg <= 1'b0;
    end else begin
      if (start_erase && start_kind != SFE_KIND_CHIP) begin
        wel_reg <= 1'b0;
      end
      if (timer_done && kind_reg == SFE_KIND_CHIP) begin
        wel_reg <= 1'b0;
      end
      if (sel_rise && !wip_reg && bit_cnt_reg == OPCODE_BITS) begin
        if (op8 == OP_WRITE_DISABLE) begin
          wel_reg <= 1'b0;
        end
        if (op8 == OP_WRITE_ENABLE) begin
          wel_reg <= 1'b1;
        end
      end
    end
  end

  // Status read stays decoded while busy so the host can poll
  assign status_byte = {3'h0, protect_level, wel_reg, wip_reg};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_status_reg <= 1'b0;
    end else if (sel_n_s) begin
      rd_status_reg <= 1'b0;
    end else if (sclk_rise && bit_cnt_reg == OPCODE_BITS - 6'h01 &&
                 shift_next[7:0] == OP_READ_STATUS) begin
      rd_status_reg <= 1'b1;
    end
  end

  // Output bits change on the serial clock fall, MSB first; the byte
  // is resampled at each boundary so repeated reads track progress
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
      out_idx_reg <= 3'h7;
      status_hold_reg <= '0;
    end else if (sel_n_s) begin
      so_oe_reg <= 1'b0;
      out_idx_reg <= 3'h7;
    end else if (rd_status_reg && sclk_fall) begin
      so_oe_reg <= 1'b1;
      out_idx_reg <= out_idx_reg - 3'h1;
      if (out_idx_reg == 3'h7) begin
        status_hold_reg <= status_byte;
        so_reg <= status_byte[7];
      end else begin
        so_reg <= status_hold_reg[out_idx_reg];
      end
    end
  end

  assign so_out = so_reg;
  assign so_oe = so_oe_reg;
  assign write_in_progress = wip_reg;
  assign write_enable_latch = wel_reg;
  assign erase_start = start_reg;
  assign erase_req = req_reg;

  // Checks
  chk_start_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    start_erase |=> wip_reg && erase_start)
    else $error("erase start did not raise busy");
  chk_start_wel: assert property (@(posedge sys_clk) disable iff (!rst_n)
    start_erase |-> wel_reg && !wip_reg)
    else $error("erase started without write enable");
  chk_frame_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sel_rise && bit_cnt_reg != ADDR_CMD_BITS &&
    bit_cnt_reg != OPCODE_BITS |-> !start_erase)
    else $error("erase started on a bad frame length");
  chk_chip_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    start_erase && bit_cnt_reg == OPCODE_BITS |->
    (op8 == OP_CHIP_ERASE_A || op8 == OP_CHIP_ERASE_B))
    else $error("eight-bit erase frame with wrong opcode");
  chk_sector_align: assert property (@(posedge sys_clk) disable iff (!rst_n)
    start_erase && start_kind == SFE_KIND_SECTOR |=>
    erase_req.base[11:0] == 12'h000)
    else $error("sector base not aligned");
  chk_prot_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    start_erase |-> !prot_hit)
    else $error("protected area erase started");
  chk_chip_prot: assert property (@(posedge sys_clk) disable iff (!rst_n)
    start_erase && start_kind == SFE_KIND_CHIP |->
    protect_level == 3'h0)
    else $error("chip erase with protection set");
  chk_wel_cleared: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(wip_reg) |-> !wel_reg)
    else $error("write enable latch survived an erase");
  chk_busy_ignore: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wip_reg && !timer_done |=> wip_reg && $stable(erase_req))
    else $error("running erase disturbed");
  chk_status_served: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    rd_status_reg && sclk_fall |=> so_oe ##0 !sel_n_s [*1])
    else $error("status read not driven");

  cov_sector: cover property (@(posedge sys_clk) disable iff (!rst_n)
    start_erase && start_kind == SFE_KIND_SECTOR);
  cov_block64: cover property (@(posedge sys_clk) disable iff (!rst_n)
    start_erase && start_kind == SFE_KIND_BLOCK64);
  cov_chip: cover property (@(posedge sys_clk) disable iff (!rst_n)
    start_erase && start_kind == SFE_KIND_CHIP);
  cov_poll_busy: cover property (@(posedge sys_clk) disable iff (!rst_n)
    wip_reg && so_oe);
endmodule

// ### testbench/sfe_host_model.sv
// Host serial controller model driving select, clock and data
`timescale 1ns/100ps
module sfe_host_model (
  input wire logic sys_clk,
  input wire logic so_out,
  output logic sel_n_pin,
  output logic sclk_pin,
  output logic si_pin
);
  initial begin
    sel_n_pin = 1'b1;
    sclk_pin = 1'b0;
    si_pin = 1'b0;
  end

  // Shifts the top n bits of d MSB first; rd keeps the last 8 bits on so
  task automatic xfer(input logic [39:0] d, input int n,
      output logic [7:0] rd);
    rd = 8'h00;
    @(posedge sys_clk);
    sel_n_pin <= 1'b0;
    // Data moves with the clock fall, giving an 800 ns link clock
    for (int i = 0; i < n; i++) begin
      si_pin <= d[39-i];
      repeat (4) @(posedge sys_clk);
      sclk_pin <= 1'b1;
      rd = {rd[6:0], so_out};
      repeat (4) @(posedge sys_clk);
      sclk_pin <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    // Clock stays low between frames; select rises only here
    sel_n_pin <= 1'b1;
    // A released data line must not keep showing the last bit
    si_pin <= ~si_pin;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule

// ### testbench/tb.sv
// Self-checking bench for the serial flash erase sequencer
`timescale 1ns/100ps
module tb;
  import sfe_pkg::*;
  // Counts long enough that a status poll fits inside every cycle
  localparam int unsigned SEC_N = 1000;
  localparam int unsigned B32_N = 1200;
  localparam int unsigned B64_N = 1400;
  localparam int unsigned CHIP_N = 1600;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] protect_level = 3'h0;
  logic sel_n_pin;
  logic sclk_pin;
  logic si_pin;
  logic so_out;
  logic so_oe;
  logic write_in_progress;
  logic write_enable_latch;
  logic erase_start;
  sfe_erase_t erase_req;
  sfe_erase_t req_seen;
  int miscompares = 0;
  int cmp_count = 0;
  int starts = 0;
  int busy_cnt = 0;
  int busy_len = 0;
  logic [7:0] rd;

  always #50 sys_clk = ~sys_clk;

  sfe_erase_ctrl #(
    .SECTOR_CYCLES(SEC_N),
    .BLOCK32_CYCLES(B32_N),
    .BLOCK64_CYCLES(B64_N),
    .CHIP_CYCLES(CHIP_N)
  ) sfe_erase_ctrl_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sel_n_pin(sel_n_pin),
    .sclk_pin(sclk_pin),
    .si_pin(si_pin),
    .protect_level(protect_level),
    .so_out(so_out),
    .so_oe(so_oe),
    .write_in_progress(write_in_progress),
    .write_enable_latch(write_enable_latch),
    .erase_start(erase_start),
    .erase_req(erase_req)
  );

  sfe_host_model sfe_host_model_i (
    .sys_clk(sys_clk),
    .so_out(so_out),
    .sel_n_pin(sel_n_pin),
    .sclk_pin(sclk_pin),
    .si_pin(si_pin)
  );

  // Records each erase start and the length of each busy period
  always @(posedge sys_clk) begin
    if (erase_start === 1'b1) begin
      starts++;
      req_seen = erase_req;
    end
    if (write_in_progress === 1'b1) begin
      busy_cnt++;
    end else if (busy_cnt != 0) begin
      busy_len = busy_cnt;
      busy_cnt = 0;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic send(input logic [7:0] op, input logic [23:0] a,
      input int n);
    sfe_host_model_i.xfer({op, a, 8'h00}, n, rd);
  endtask

  task automatic refused(input logic [7:0] op, input logic [23:0] a,
      input int n);
    int s0;
    s0 = starts;
    send(op, a, n);
    check(starts, s0);
    check(write_in_progress, 1'b0);
  endtask

  task automatic t_reset();
    check({write_in_progress, write_enable_latch, erase_start, so_oe},
      4'h0);
    $display("t_reset done");
  endtask

  task automatic t_status();
    @(posedge sys_clk);
    protect_level <= 3'h5;
    send(OP_READ_STATUS, 24'h0, 16);
    check(rd, {3'h0, 3'h5, 2'h0});
    check(so_oe, 1'b0);
    @(posedge sys_clk);
    protect_level <= 3'h0;
    $display("t_status done");
  endtask

  task automatic t_no_wel();
    refused(OP_SECTOR_ERASE, 24'h001000, 32);
    refused(OP_CHIP_ERASE_B, 24'h0, 8);
    $display("t_no_wel done");
  endtask

  task automatic t_erase(input logic [7:0] op, input logic [23:0] a,
      input sfe_kind_t kind, input logic [16:0] base, input int n);
    int s0;
    logic chip;
    chip = (kind == SFE_KIND_CHIP);
    send(OP_WRITE_ENABLE, 24'h0, 8);
    check(write_enable_latch, 1'b1);
    s0 = starts;
    send(op, a, chip ? 8 : 32);
    check(starts, s0 + 1);
    check(req_seen.kind, kind);
    if (!chip) begin
      check(req_seen.base, base);
    end
    check(write_in_progress, 1'b1);
    check(write_enable_latch, chip);
    send(OP_READ_STATUS, 24'h0, 16);
    check(rd, {3'h0, protect_level, chip, 1'b1});
    // Latch-changing opcodes and a fresh erase must both be ignored
    send(chip ? OP_WRITE_DISABLE : OP_WRITE_ENABLE, 24'h0, 8);
    send(OP_SECTOR_ERASE, 24'h0, 32);
    check(starts, s0 + 1);
    check(write_enable_latch, chip);
    for (int i = 0; i < 5000 && write_in_progress === 1'b1; i++) begin
      @(posedge sys_clk);
    end
    repeat (2) @(posedge sys_clk);
    check(busy_len >= n && busy_len <= n + 2, 1'b1);
    check(write_in_progress, 1'b0);
    check(write_enable_latch, 1'b0);
    $display("t_erase %h done", op);
  endtask

  task automatic t_bad_len();
    send(OP_WRITE_ENABLE, 24'h0, 8);
    refused(OP_SECTOR_ERASE, 24'h002000, 31);
    refused(OP_SECTOR_ERASE, 24'h002000, 33);
    refused(OP_CHIP_ERASE_A, 24'h0, 9);
    refused(OP_CHIP_ERASE_B, 24'h0, 7);
    check(write_enable_latch, 1'b1);
    // An idle write disable must drop the latch and block erases
    send(OP_WRITE_DISABLE, 24'h0, 8);
    check(write_enable_latch, 1'b0);
    refused(OP_BLOCK64_ERASE, 24'h000000, 32);
    $display("t_bad_len done");
  endtask

  task automatic t_protect();
    @(posedge sys_clk);
    protect_level <= 3'h1;
    send(OP_WRITE_ENABLE, 24'h0, 8);
    refused(OP_SECTOR_ERASE, 24'h01f123, 32);
    refused(OP_BLOCK32_ERASE, 24'h018000, 32);
    refused(OP_BLOCK64_ERASE, 24'h010000, 32);
    refused(OP_CHIP_ERASE_A, 24'h0, 8);
    // Sector just below the protected top 8KB must still erase
    t_erase(OP_SECTOR_ERASE, 24'h01dfff, SFE_KIND_SECTOR, 17'h1d000,
      SEC_N);
    @(posedge sys_clk);
    protect_level <= 3'h0;
    $display("t_protect done");
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_status();
    t_no_wel();
    t_erase(OP_SECTOR_ERASE, 24'h001234, SFE_KIND_SECTOR, 17'h01000,
      SEC_N);
    t_erase(OP_BLOCK32_ERASE, 24'h00abcd, SFE_KIND_BLOCK32, 17'h08000,
      B32_N);
    t_erase(OP_BLOCK64_ERASE, 24'h01ffff, SFE_KIND_BLOCK64, 17'h10000,
      B64_N);
    t_erase(OP_CHIP_ERASE_A, 24'h0, SFE_KIND_CHIP, 17'h0,
      CHIP_N);
    t_erase(OP_CHIP_ERASE_B, 24'h0, SFE_KIND_CHIP, 17'h0,
      CHIP_N);
    t_bad_len();
    t_protect();
    test_done();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    test_done();
  end
endmodule
